// ===== rtl/ihba_idx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ihba_idx_mem (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic wr_sel,
	input wire logic [ihba_pkg::IDX_BYTES-1:0] wr_be,
	input wire logic [ihba_pkg::IDX_W-1:0] wr_data,
	input wire logic rd_sel,
	output logic [ihba_pkg::IDX_W-1:0] rd_data
);
	logic [ihba_pkg::IDX_W-1:0] mem_q [ihba_pkg::NUM_IDX];
	logic [ihba_pkg::IDX_W-1:0] rd_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int e = 0; e < ihba_pkg::NUM_IDX; e++) begin
				mem_q[e] <= ihba_pkg::IDX_RST;
			end
			rd_q <= ihba_pkg::IDX_RST;
		end else begin
			for (int b = 0; b < ihba_pkg::IDX_BYTES; b++) begin
				if (wr_en && wr_be[b]) begin
					mem_q[wr_sel][8*b +: 8] <= wr_data[8*b +: 8];
				end
			end
			rd_q <= mem_q[rd_sel];
		end
	end

	assign rd_data = rd_q;
endmodule
`default_nettype wire

// ===== rtl/ihba_pkg.sv
package ihba_pkg;
	// host side geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int SYNC_W = 3 + ADDR_W + DATA_W;
	// index register: three usable bytes, the top byte is reserved
	localparam int IDX_W = 24;
	localparam int IDX_BYTES = 3;
	localparam int NUM_IDX = 2;
	localparam int INT_AW = 24;
	localparam logic [IDX_W-1:0] IDX_RST = 24'h000000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	// host address fields: slot in [3:2], byte in [1:0]
	localparam int SLOT_LSB = 2;
	localparam int WORD_BIT = 1;
	localparam int PAIR_BIT = 3;
	localparam int KIND_BIT = 2;
	// slot kind taken from KIND_BIT: 0 index register, 1 data register
	localparam logic KIND_INDEX = 1'b0;
	typedef enum logic [2:0] {
		IHBA_IDLE,
		IHBA_RD_ADDR,
		IHBA_RD_WAIT,
		IHBA_RD_HOLD,
		IHBA_NPW_HOLD,
		IHBA_WR_OPEN
	} ihba_state_t;
endpackage

// ===== rtl/ihba_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ihba_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two flops per bit; the first is read only by the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== rtl/ihba_top.sv
`timescale 1ns/1ps
`default_nettype none
module ihba_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfg_wide,
	input wire logic cfg_posted,
	input wire logic cfg_cs_pol,
	input wire logic cfg_rd_pol,
	input wire logic cfg_wr_pol,
	input wire logic cfg_wait_pol,
	input wire logic host_cs,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [ihba_pkg::ADDR_W-1:0] host_addr,
	input wire logic [ihba_pkg::DATA_W-1:0] host_data_in,
	output logic [ihba_pkg::DATA_W-1:0] host_data_out,
	output logic host_data_oe_lo,
	output logic host_data_oe_hi,
	output logic host_wait_out,
	output logic host_wait_oe,
	output logic int_req,
	output logic int_we,
	output logic [ihba_pkg::INT_AW-1:0] int_addr,
	output logic [3:0] int_be,
	output logic [31:0] int_wdata,
	input wire logic [31:0] int_rdata,
	input wire logic int_ack,
	output logic write_pending
);
	logic [ihba_pkg::SYNC_W-1:0] raw;
	logic [ihba_pkg::SYNC_W-1:0] syn;
	logic cs_s, rd_s, wr_s, hold;
	logic [ihba_pkg::ADDR_W-1:0] addr_s;
	logic [ihba_pkg::DATA_W-1:0] data_s;
	ihba_pkg::ihba_state_t state_q, state_d;
	logic [ihba_pkg::ADDR_W-1:0] acc_q, acc_d;
	logic [ihba_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic wbusy_q, wbusy_d, pend_q, pend_d;
	logic ireq_q, ireq_d, iwe_q, iwe_d;
	logic [ihba_pkg::INT_AW-1:0] iaddr_q, iaddr_d;
	logic [3:0] ibe_q, ibe_d;
	logic [31:0] iwd_q, iwd_d;
	logic mem_we;
	logic [ihba_pkg::IDX_W-1:0] idx_rd;
	logic [31:0] wd32, idx32;
	logic [3:0] be32;
	logic acc_is_idx;
	logic [1:0] arm_q, arm_d;

	// byte enables over a 32-bit word for the latched host address
	function automatic logic [3:0] lane_be(input logic wide,
		input logic [ihba_pkg::ADDR_W-1:0] a);
		if (wide) begin
			lane_be = a[ihba_pkg::WORD_BIT] ? 4'hC : 4'h3;
		end else begin
			lane_be = 4'h1 << a[1:0];
		end
	endfunction

	// pick the host lanes out of a 32-bit word
	function automatic logic [15:0] lane_pick(input logic wide,
		input logic [ihba_pkg::ADDR_W-1:0] a, input logic [31:0] w);
		if (wide) begin
			lane_pick = a[ihba_pkg::WORD_BIT] ? w[31:16] : w[15:0];
		end else begin
			lane_pick = {8'h00, w[8*a[1:0] +: 8]};
		end
	endfunction

	assign raw = {host_cs, host_rd, host_wr, host_addr, host_data_in};

	ihba_sync #(.W(ihba_pkg::SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(raw),
		.sync_out(syn)
	);

	// strobes act only after two flops, then polarity is applied
	// reset flops read as active for a low pin: select waits for real levels
	assign cs_s = arm_q[1] &&
		(syn[ihba_pkg::SYNC_W-1] ~^ cfg_cs_pol);
	assign rd_s = syn[ihba_pkg::SYNC_W-2] ~^ cfg_rd_pol;
	assign wr_s = syn[ihba_pkg::SYNC_W-3] ~^ cfg_wr_pol;
	assign addr_s = syn[ihba_pkg::DATA_W +: ihba_pkg::ADDR_W];
	// narrow mode never looks at the upper lanes
	assign data_s = cfg_wide ? syn[ihba_pkg::DATA_W-1:0] :
		{8'h00, syn[7:0]};

	assign acc_is_idx = acc_q[ihba_pkg::KIND_BIT] == ihba_pkg::KIND_INDEX;
	assign wd32 = cfg_wide ? {wdat_q, wdat_q} : {4{wdat_q[7:0]}};
	assign be32 = lane_be(cfg_wide, acc_q);
	// reserved top byte of an index register reads as zero
	assign idx32 = {8'h00, idx_rd};

	ihba_idx_mem u_idx (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(mem_we),
		.wr_sel(acc_q[ihba_pkg::PAIR_BIT]),
		.wr_be(be32[ihba_pkg::IDX_BYTES-1:0]),
		.wr_data(wd32[ihba_pkg::IDX_W-1:0]),
		.rd_sel(acc_q[ihba_pkg::PAIR_BIT]),
		.rd_data(idx_rd)
	);

	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		wbusy_d = wbusy_q;
		pend_d = pend_q;
		ireq_d = ireq_q;
		iwe_d = iwe_q;
		iaddr_d = iaddr_q;
		ibe_d = ibe_q;
		iwd_d = iwd_q;
		mem_we = 1'b0;
		hold = 1'b0;
		arm_d = {arm_q[0], 1'b1};
		// commit engine for writes already released by the host
		if (wbusy_q) begin
			if (acc_is_idx) begin
				mem_we = 1'b1;
				wbusy_d = 1'b0;
				pend_d = 1'b0;
			end else if (!ireq_q) begin
				ireq_d = 1'b1;
				iwe_d = 1'b1;
				iaddr_d = {idx_rd[ihba_pkg::IDX_W-1:2], 2'b00};
				ibe_d = be32;
				iwd_d = wd32;
			end else if (int_ack) begin
				ireq_d = 1'b0;
				wbusy_d = 1'b0;
				pend_d = 1'b0;
			end
		end
		case (state_q)
			ihba_pkg::IHBA_IDLE: begin
				// held at select only for a pending write or a new strobe
				hold = pend_q || (cs_s && (rd_s || (wr_s && !cfg_posted)));
				if (cs_s && !wbusy_q && rd_s) begin
					acc_d = addr_s;
					state_d = ihba_pkg::IHBA_RD_ADDR;
				end else if (cs_s && !wbusy_q && wr_s) begin
					acc_d = addr_s;
					wdat_d = data_s;
					state_d = cfg_posted ? ihba_pkg::IHBA_WR_OPEN :
						ihba_pkg::IHBA_NPW_HOLD;
				end
			end
			ihba_pkg::IHBA_RD_ADDR: begin
				hold = 1'b1;
				state_d = ihba_pkg::IHBA_RD_WAIT;
			end
			ihba_pkg::IHBA_RD_WAIT: begin
				hold = 1'b1;
				if (acc_is_idx) begin
					rdat_d = lane_pick(cfg_wide, acc_q, idx32);
					state_d = ihba_pkg::IHBA_RD_HOLD;
				end else if (!ireq_q) begin
					if (!(cs_s && rd_s)) begin
						state_d = ihba_pkg::IHBA_IDLE;
					end else begin
						ireq_d = 1'b1;
						iwe_d = 1'b0;
						iaddr_d = {idx_rd[ihba_pkg::IDX_W-1:2], 2'b00};
						ibe_d = be32;
					end
				end else if (int_ack) begin
					ireq_d = 1'b0;
					rdat_d = lane_pick(cfg_wide, acc_q, int_rdata);
					state_d = ihba_pkg::IHBA_RD_HOLD;
				end
			end
			ihba_pkg::IHBA_RD_HOLD: begin
				if (!(cs_s && rd_s)) begin
					state_d = ihba_pkg::IHBA_IDLE;
				end
			end
			ihba_pkg::IHBA_NPW_HOLD: begin
				// one cycle to accept, then the host may release
				hold = 1'b1;
				wdat_d = data_s;
				state_d = ihba_pkg::IHBA_WR_OPEN;
			end
			ihba_pkg::IHBA_WR_OPEN: begin
				if (cs_s && wr_s) begin
					wdat_d = data_s;
				end else begin
					// trailing edge: the last sample is written
					wbusy_d = 1'b1;
					pend_d = cfg_posted;
					state_d = ihba_pkg::IHBA_IDLE;
				end
			end
			default: begin
				state_d = ihba_pkg::IHBA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= ihba_pkg::IHBA_IDLE;
			arm_q <= 2'h0;
			acc_q <= '0;
			wdat_q <= ihba_pkg::DATA_RST;
			rdat_q <= ihba_pkg::DATA_RST;
			wbusy_q <= 1'b0;
			pend_q <= 1'b0;
			ireq_q <= 1'b0;
			iwe_q <= 1'b0;
			iaddr_q <= '0;
			ibe_q <= 4'h0;
			iwd_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			arm_q <= arm_d;
			acc_q <= acc_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			wbusy_q <= wbusy_d;
			pend_q <= pend_d;
			ireq_q <= ireq_d;
			iwe_q <= iwe_d;
			iaddr_q <= iaddr_d;
			ibe_q <= ibe_d;
			iwd_q <= iwd_d;
		end
	end

	// hold-off floats whenever select is inactive
	assign host_wait_oe = cs_s;
	assign host_wait_out = hold ? cfg_wait_pol : ~cfg_wait_pol;
	// read lanes are driven from the cycle after the strobe is seen until it ends, valid after hold drops
	assign host_data_oe_lo = cs_s && rd_s && (state_q == ihba_pkg::IHBA_RD_ADDR ||
		state_q == ihba_pkg::IHBA_RD_WAIT ||
		state_q == ihba_pkg::IHBA_RD_HOLD);
	assign host_data_oe_hi = host_data_oe_lo && cfg_wide;
	assign host_data_out = rdat_q;
	assign int_req = ireq_q;
	assign int_we = iwe_q;
	assign int_addr = iaddr_q;
	assign int_be = ibe_q;
	assign int_wdata = iwd_q;
	assign write_pending = pend_q;

	chk_wait_float: assert property (@(posedge clk_sys) disable iff (rst)
		!(syn[ihba_pkg::SYNC_W-1] ~^ cfg_cs_pol) |-> !host_wait_oe)
		else $error("hold-off driven without chip select");
	chk_posted_start: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cs_s) && !rd_s && !wr_s && cfg_posted |-> hold == pend_q)
		else $error("posted access start level wrong");
	chk_posted_release: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_WR_OPEN && cfg_posted && cs_s && !wr_s
		|=> pend_q && hold)
		else $error("posted write release not held off");
	chk_posted_together: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_WR_OPEN && cfg_posted && !cs_s && !wr_s
		|-> !host_wait_oe ##1 wbusy_q)
		else $error("joint release lost write or showed hold");
	chk_wr_sample: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_WR_OPEN && cs_s && wr_s |=> wdat_q == $past(data_s))
		else $error("write data not tracked to trailing edge");
	chk_np_start: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_IDLE && cs_s && !rd_s && !wr_s && !pend_q
		|-> !hold)
		else $error("idle select held off without cause");
	chk_np_accept: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_IDLE && cs_s && wr_s && !rd_s && !wbusy_q
		&& !cfg_posted |-> hold ##1 hold ##1 !hold)
		else $error("non-posted write hold sequence wrong");
	chk_rd_held: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_IDLE && cs_s && rd_s && !wbusy_q
		|-> hold ##1 hold ##1 hold)
		else $error("read not held off at strobe");
	chk_rd_valid: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ihba_pkg::IHBA_RD_HOLD && cs_s && rd_s |-> !hold && host_data_oe_lo)
		else $error("read data not driven when released");
	chk_narrow_hi: assert property (@(posedge clk_sys) disable iff (rst)
		!cfg_wide |-> !host_data_oe_hi)
		else $error("upper lanes driven in narrow mode");
	chk_route_index: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(ireq_q) |-> iaddr_q == {idx_rd[ihba_pkg::IDX_W-1:2], 2'b00})
		else $error("internal access not routed by index");
endmodule
`default_nettype wire

// ===== sim/ihba_int_model.sv
`timescale 1ns/1ps
`default_nettype none
module ihba_int_model (
	input wire logic clk_sys,
	input wire logic [3:0] delay,
	input wire logic int_req,
	input wire logic int_we,
	input wire logic [23:0] int_addr,
	input wire logic [3:0] int_be,
	input wire logic [31:0] int_wdata,
	output logic [31:0] int_rdata,
	output logic int_ack,
	output logic [23:0] last_addr
);
	// small store: word address bits [9:2] pick the entry, higher bits alias
	logic [31:0] mem [256];
	logic [31:0] word;
	logic [3:0] cnt;
	initial begin
		int_ack = 1'b0;
		int_rdata = 32'h0;
		cnt = 4'h0;
		last_addr = 24'h0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'h0;
		end
	end
	// answers after a programmable stall; read data toggles outside ack
	always @(posedge clk_sys) begin
		int_ack <= 1'b0;
		int_rdata <= ~int_rdata;
		if (!int_req || int_ack) begin
			cnt <= 4'h0;
		end else if (cnt != delay) begin
			cnt <= cnt + 4'h1;
		end else begin
			word = mem[int_addr[9:2]];
			for (int i = 0; i < 4; i++) begin
				if (int_we && int_be[i]) begin
					word[i*8 +: 8] = int_wdata[i*8 +: 8];
				end
			end
			mem[int_addr[9:2]] = word;
			int_rdata <= word;
			int_ack <= 1'b1;
			last_addr <= int_addr;
		end
	end
endmodule
`default_nettype wire

// ===== sim/test_indexed_host_bus_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_indexed_host_bus_access;
	logic clk_sys, rst, cfg_wide, cfg_posted, cfg_cs_pol, cfg_rd_pol;
	logic cfg_wr_pol, cfg_wait_pol, cs_a, rd_a, wr_a, host_cs, host_rd, host_wr;
	logic [3:0] host_addr, dly, int_be;
	logic [15:0] host_data_in, host_data_out;
	logic oe_lo, oe_hi, wait_out, wait_oe, int_req, int_we, int_ack, wp;
	logic [23:0] int_addr, last_addr;
	logic [31:0] int_wdata, int_rdata;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	assign host_cs = cs_a ~^ cfg_cs_pol;
	assign host_rd = rd_a ~^ cfg_rd_pol;
	assign host_wr = wr_a ~^ cfg_wr_pol;
	ihba_top dut_u (.clk_sys(clk_sys), .rst(rst), .cfg_wide(cfg_wide),
		.cfg_posted(cfg_posted), .cfg_cs_pol(cfg_cs_pol),
		.cfg_rd_pol(cfg_rd_pol), .cfg_wr_pol(cfg_wr_pol),
		.cfg_wait_pol(cfg_wait_pol), .host_cs(host_cs), .host_rd(host_rd),
		.host_wr(host_wr), .host_addr(host_addr), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe_lo(oe_lo),
		.host_data_oe_hi(oe_hi), .host_wait_out(wait_out),
		.host_wait_oe(wait_oe), .int_req(int_req), .int_we(int_we),
		.int_addr(int_addr), .int_be(int_be), .int_wdata(int_wdata),
		.int_rdata(int_rdata), .int_ack(int_ack), .write_pending(wp));
	ihba_int_model mem_u (.clk_sys(clk_sys), .delay(dly), .int_req(int_req),
		.int_we(int_we), .int_addr(int_addr), .int_be(int_be),
		.int_wdata(int_wdata), .int_rdata(int_rdata), .int_ack(int_ack),
		.last_addr(last_addr));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic held();
		return wait_oe === 1'b1 && wait_out === cfg_wait_pol;
	endfunction
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic wait_hold(input logic lvl);
		int n;
		n = 0;
		while (held() !== lvl && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	// chip select first (lead cycles) or together with the strobe
	task automatic open_acc(input logic [3:0] a, input logic rd, input int lead,
		input logic exp_start);
		int n;
		n = 0;
		host_addr = a;
		cs_a = 1'b1;
		rd_a = rd & (lead == 0);
		wr_a = !rd & (lead == 0);
		while (wait_oe !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		check("start hold", held(), exp_start);
		if (lead > 0) begin
			repeat (lead) @(negedge clk_sys);
			rd_a = rd;
			wr_a = !rd;
		end
	endtask
	task automatic hwr(input logic [3:0] a, input logic [15:0] d, input int lead,
		input logic exp_start, input logic keep_cs);
		logic seen;
		seen = 1'b0;
		host_data_in = cfg_posted ? ~d : d;
		open_acc(a, 1'b0, lead, exp_start);
		if (!cfg_posted) begin
			wait_hold(1'b1);
			check("npw hold", held(), 1'b1);
		end else begin
			repeat (2) @(negedge clk_sys);
			host_data_in = d;
			repeat (3) @(negedge clk_sys);
		end
		wait_hold(1'b0);
		check("wr release", held(), 1'b0);
		wr_a = 1'b0;
		if (!keep_cs)
			cs_a = 1'b0;
		if (keep_cs) begin
			wait_hold(1'b1);
			check("posted hold", held(), 1'b1);
			check("pending", wp, 1'b1);
			wait_hold(1'b0);
		end
		repeat (4) begin
			@(negedge clk_sys);
			seen = seen | held();
		end
		check("drop hold", seen, 1'b0);
		cs_a = 1'b0;
		repeat (8) @(negedge clk_sys);
		check("wait oe idle", wait_oe, 1'b0);
	endtask
	task automatic hrd(input logic [3:0] a, input int lead, input logic exp_start,
		input logic [15:0] exp, input logic [15:0] mask);
		open_acc(a, 1'b1, lead, exp_start);
		wait_hold(1'b1);
		check("rd hold", held(), 1'b1);
		wait_hold(1'b0);
		check("rd data", host_data_out & mask, exp);
		check("oe lo", oe_lo, 1'b1);
		check("oe hi", oe_hi, cfg_wide);
		rd_a = 1'b0;
		cs_a = 1'b0;
		repeat (6) @(negedge clk_sys);
		check("oe off", oe_lo, 1'b0);
	endtask
	task automatic t_index_wide();
		hwr(4'h0, 16'h1234, 2, 1'b0, 1'b0);
		hwr(4'h2, 16'hAB56, 0, 1'b1, 1'b0);
		hrd(4'h0, 0, 1'b1, 16'h1234, 16'hFFFF);
		hrd(4'h2, 2, 1'b0, 16'h0056, 16'h00FF);
		$display("done index wide");
	endtask
	task automatic t_data_wide();
		hwr(4'h4, 16'hBEEF, 1, 1'b0, 1'b0);
		check("route 0", last_addr, 24'h561234);
		hwr(4'h8, 16'h0040, 1, 1'b0, 1'b0);
		hwr(4'hE, 16'hCAFE, 1, 1'b0, 1'b0);
		check("route 1", last_addr, 24'h000040);
		hrd(4'hE, 1, 1'b0, 16'hCAFE, 16'hFFFF);
		hrd(4'h4, 1, 1'b0, 16'hBEEF, 16'hFFFF);
		$display("done data wide");
	endtask
	task automatic t_posted();
		cfg_posted = 1'b1;
		hwr(4'h8, 16'h0080, 2, 1'b0, 1'b1);
		hrd(4'h8, 2, 1'b0, 16'h0080, 16'hFFFF);
		dly = 4'hF;
		hwr(4'hC, 16'h1357, 2, 1'b0, 1'b0);
		check("pend after", wp, 1'b1);
		cs_a = 1'b1;
		wait_hold(1'b1);
		check("pend start", held(), 1'b1);
		wait_hold(1'b0);
		check("pend clear", wp, 1'b0);
		cs_a = 1'b0;
		dly = 4'h0;
		repeat (4) @(negedge clk_sys);
		hrd(4'hC, 1, 1'b0, 16'h1357, 16'hFFFF);
		cfg_posted = 1'b0;
		$display("done posted");
	endtask
	task automatic t_narrow_inverted();
		cfg_wide = 1'b0;
		{cfg_cs_pol, cfg_rd_pol, cfg_wr_pol, cfg_wait_pol} = 4'h1;
		do_reset();
		hwr(4'h1, 16'hEE9A, 1, 1'b0, 1'b0);
		hwr(4'h3, 16'h0077, 1, 1'b0, 1'b0);
		hrd(4'h1, 0, 1'b1, 16'h009A, 16'h00FF);
		hwr(4'h4, 16'h5511, 1, 1'b0, 1'b0);
		check("route n", last_addr, 24'h009A00);
		hrd(4'h4, 1, 1'b0, 16'h0011, 16'h00FF);
		$display("done narrow inverted");
	endtask
	initial begin
		{rst, cs_a, rd_a, wr_a, cfg_posted} = 5'h10;
		{cfg_wide, cfg_cs_pol, cfg_rd_pol, cfg_wr_pol, cfg_wait_pol} = 5'h1E;
		host_addr = 4'h0;
		host_data_in = 16'h0000;
		dly = 4'h0;
		do_reset();
		t_index_wide();
		t_data_wide();
		t_posted();
		t_narrow_inverted();
		report_and_stop();
	end
endmodule
`default_nettype wire
